// file: src/rcc_reset_cause.sv
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// RL1: master clear pin reset sets bit 7; stays set until software clears it.
// RL2: reset instruction sets bit 6; reads set until software clears it.
// RL3: illegal opcode, address mode or uninitialised pointer resets and sets bit 14.
// RL4: bit 13 written 1 enables brown-out detection; written 0 disables it.
// RL5: bit 8 clear powers memory bias down when regulator enters standby.
// RL6: unprogrammed watchdog fuse keeps watchdog enabled regardless of software bit.
// RL7: software may set or clear any flag; writing never causes a reset.
// RL8: power-on sets power-on and brown-out flags, others zero; bit 11 reads zero.
module rcc_reset_cause (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        master_clear_pin_in,
  input  wire logic        reset_instr_in,
  input  wire logic        illegal_opcode_in,
  input  wire logic        illegal_addr_mode_in,
  input  wire logic        uninit_pointer_in,
  input  wire logic        trap_conflict_in,
  input  wire logic        config_mismatch_in,
  input  wire logic        watchdog_timeout_in,
  input  wire logic        brownout_in,
  input  wire logic        deep_sleep_in,
  input  wire logic        sleep_entry_in,
  input  wire logic        idle_entry_in,
  input  wire logic        regulator_standby_in,
  input  wire logic        watchdog_config_fuse_in,
  output logic             brownout_detect_en_out,
  output logic             watchdog_en_out,
  output logic             memory_bias_en_out,
  output logic             retention_sleep_control_out,
  output logic             core_reset_req_out,
  output logic             irq_out
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]  pin_sync;
    logic [1:0]  fuse_sync;
    logic        pin_prev;
    logic [15:0] control;
    logic [15:0] irq_status;
    logic [15:0] irq_mask;
    logic [31:0] rdata;
    logic        core_reset;
    logic        bor_en;
    logic        wdt_en;
    logic        bias_en;
    logic        ret_ctl;
  } rcc_state_s;

  rcc_state_s state;
  rcc_state_s next_state;

  // apply byte strobes of a 32-bit write to a 16-bit register
  function automatic logic [15:0] rcc_strobe_write(input logic [15:0] old_val,
                                                   input logic [31:0] wdata,
                                                   input logic [3:0]  strb);
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        pin_rise;
  logic [15:0] events;

  assign access   = psel_in && penable_in;
  assign addr_ok  = (paddr_in == rcc_pkg::RESET_CAUSE_CONTROL_OFF) ||
                    (paddr_in == rcc_pkg::IRQ_STATUS_OFF) ||
                    (paddr_in == rcc_pkg::IRQ_MASK_OFF);
  assign wr_en    = access && pwrite_in && addr_ok;
  assign rd_en    = access && !pwrite_in && addr_ok;
  // the pin is asynchronous: only the second stage is looked at
  assign pin_rise = state.pin_sync[1] && !state.pin_prev;

  always_comb begin
    events = 16'h0000;
    events[rcc_pkg::EXTERNAL_PIN_BIT]    = pin_rise;                                  // [RL1]
    events[rcc_pkg::SOFTWARE_RESET_BIT]  = reset_instr_in;                            // [RL2]
    events[rcc_pkg::ILLEGAL_OP_BIT]      = illegal_opcode_in || illegal_addr_mode_in ||
                                           uninit_pointer_in;                         // [RL3]
    events[rcc_pkg::TRAP_CONFLICT_BIT]   = trap_conflict_in;
    events[rcc_pkg::CONFIG_MISMATCH_BIT] = config_mismatch_in;
    events[rcc_pkg::WATCHDOG_BIT]        = watchdog_timeout_in;
    events[rcc_pkg::BROWNOUT_BIT]        = brownout_in && state.bor_en;
    events[rcc_pkg::DEEP_SLEEP_BIT]      = deep_sleep_in;
    events[rcc_pkg::SLEEP_BIT]           = sleep_entry_in;
    events[rcc_pkg::IDLE_BIT]            = idle_entry_in;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state           = state;
    next_state.pin_sync  = {state.pin_sync[0], master_clear_pin_in};
    next_state.fuse_sync = {state.fuse_sync[0], watchdog_config_fuse_in};
    next_state.pin_prev  = state.pin_sync[1];
    // software write first, then hardware events so a set wins over a clear
    if (wr_en && paddr_in == rcc_pkg::RESET_CAUSE_CONTROL_OFF) begin
      next_state.control = rcc_strobe_write(state.control, pwdata_in, pstrb_in); // [RL7]
    end
    if (wr_en && paddr_in == rcc_pkg::IRQ_MASK_OFF) begin
      next_state.irq_mask = rcc_strobe_write(state.irq_mask, pwdata_in, pstrb_in);
    end
    next_state.control = (next_state.control | events) & rcc_pkg::CONTROL_IMPL_MASK; // [RL1] [RL2] [RL3] [RL8]
    // read of the interrupt status clears it, events of this cycle stay
    if (rd_en && paddr_in == rcc_pkg::IRQ_STATUS_OFF) begin
      next_state.irq_status = events & rcc_pkg::CONTROL_IMPL_MASK;
    end else begin
      next_state.irq_status = (state.irq_status | events) & rcc_pkg::CONTROL_IMPL_MASK;
    end
    // only hardware events reset the core; software writes never do
    next_state.core_reset = |(events & rcc_pkg::CORE_RESET_EVENTS);              // [RL3] [RL7]
    next_state.bor_en  = next_state.control[rcc_pkg::SW_BROWNOUT_EN_BIT];        // [RL4]
    next_state.wdt_en  = state.fuse_sync[1] ||
                         next_state.control[rcc_pkg::SW_WATCHDOG_EN_BIT];        // [RL6]
    next_state.bias_en = next_state.control[rcc_pkg::SLEEP_MEM_POWER_BIT] ||
                         !regulator_standby_in;                                  // [RL5]
    next_state.ret_ctl = next_state.control[rcc_pkg::RETENTION_BIT];
    next_state.rdata   = 32'h0000_0000;
    if (rd_en) begin
      case (paddr_in)
        rcc_pkg::RESET_CAUSE_CONTROL_OFF: next_state.rdata = {16'h0000, state.control};
        rcc_pkg::IRQ_STATUS_OFF:          next_state.rdata = {16'h0000, state.irq_status};
        rcc_pkg::IRQ_MASK_OFF:            next_state.rdata = {16'h0000, state.irq_mask};
        default:                          next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state            <= '0;
      state.control    <= rcc_pkg::CONTROL_RESET_VAL;                             // [RL8]
      state.irq_status <= 16'h0000;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data is not registered: it is decoded combinationally from the registers during the access phase
  always_comb begin
    prdata_out = 32'h0000_0000;
    if (rd_en) begin
      case (paddr_in)
        rcc_pkg::RESET_CAUSE_CONTROL_OFF: prdata_out = {16'h0000, state.control};
        rcc_pkg::IRQ_STATUS_OFF:          prdata_out = {16'h0000, state.irq_status};
        rcc_pkg::IRQ_MASK_OFF:            prdata_out = {16'h0000, state.irq_mask};
        default:                          prdata_out = 32'h0000_0000;
      endcase
    end
  end

  assign pready_out                  = 1'b1;
  assign pslverr_out                 = access && !addr_ok;
  assign brownout_detect_en_out      = state.bor_en;
  assign watchdog_en_out             = state.wdt_en;
  assign memory_bias_en_out          = state.bias_en;
  assign retention_sleep_control_out = state.ret_ctl;
  assign core_reset_req_out          = state.core_reset;
  assign irq_out                     = |(state.irq_status & state.irq_mask);

endmodule

// file: include/rcc_pkg.sv
package rcc_pkg;

  // register map
  localparam logic [11:0] RESET_CAUSE_CONTROL_OFF = 12'h000;
  localparam logic [11:0] IRQ_STATUS_OFF          = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFF            = 12'h008;

  // field positions of reset_cause_control
  localparam int TRAP_CONFLICT_BIT   = 15;
  localparam int ILLEGAL_OP_BIT      = 14;
  localparam int SW_BROWNOUT_EN_BIT  = 13;
  localparam int RETENTION_BIT       = 12;
  localparam int DEEP_SLEEP_BIT      = 10;
  localparam int CONFIG_MISMATCH_BIT = 9;
  localparam int SLEEP_MEM_POWER_BIT = 8;
  localparam int EXTERNAL_PIN_BIT    = 7;
  localparam int SOFTWARE_RESET_BIT  = 6;
  localparam int SW_WATCHDOG_EN_BIT  = 5;
  localparam int WATCHDOG_BIT        = 4;
  localparam int SLEEP_BIT           = 3;
  localparam int IDLE_BIT            = 2;
  localparam int BROWNOUT_BIT        = 1;
  localparam int POWER_ON_BIT        = 0;

  // implemented bits (bit 11 unimplemented) and value after power-on
  localparam logic [15:0] CONTROL_IMPL_MASK = 16'hF7FF;
  localparam logic [15:0] CONTROL_RESET_VAL = 16'h0003;
  // bits that are software controls, not event flags
  localparam logic [15:0] CONTROL_SW_MASK   = 16'h3120;
  // event inputs that also reset the core
  localparam logic [15:0] CORE_RESET_EVENTS = 16'hC2D3;

endpackage

// file: verification/rcc_reset_cause_chk.sv
`timescale 1ns/1ps
module rcc_reset_cause_chk (
  input wire logic        clk_in, sys_rst_in, psel_in, penable_in, pwrite_in, master_clear_pin_in,
  input wire logic        reset_instr_in, illegal_opcode_in, illegal_addr_mode_in, uninit_pointer_in,
  input wire logic        trap_conflict_in, config_mismatch_in, watchdog_timeout_in, brownout_in,
  input wire logic        regulator_standby_in, watchdog_config_fuse_in, core_reset_req_out,
  input wire logic        watchdog_en_out, memory_bias_en_out, brownout_detect_en_out,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in, prdata_out,
  input wire logic [3:0]  pstrb_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire acc = psel_in & penable_in;
  wire ev = reset_instr_in | illegal_opcode_in | illegal_addr_mode_in | uninit_pointer_in | trap_conflict_in
            | config_mismatch_in | watchdog_timeout_in | brownout_in;
  ////////////////////////////////////////////////////////////////////////////
  pin_rst_a: assert property ($rose(master_clear_pin_in) |-> ##[1:5] core_reset_req_out)
    else $error("pin reset not requested");
  instr_rst_a: assert property (reset_instr_in |=> core_reset_req_out)
    else $error("reset instruction not requested");
  illegal_rst_a: assert property ((illegal_opcode_in | illegal_addr_mode_in | uninit_pointer_in) |=> core_reset_req_out)
    else $error("illegal operation not requested");
  bor_ctrl_a: assert property (acc && pwrite_in && paddr_in == 12'h000 && pstrb_in[1] |->
    ##2 brownout_detect_en_out == $past(pwdata_in[13], 2)) else $error("brownout enable wrong");
  bias_on_a: assert property (!regulator_standby_in [*2] |=> memory_bias_en_out)
    else $error("memory bias dropped");
  fuse_wdt_a: assert property (watchdog_config_fuse_in [*4] |=> watchdog_en_out)
    else $error("watchdog not forced on");
  quiet_write_a: assert property ((!ev && !master_clear_pin_in) [*5] |=> !core_reset_req_out)
    else $error("reset without cause");
  unimpl_zero_a: assert property (acc && !pwrite_in && paddr_in == 12'h000 |->
    prdata_out[11] == 1'b0 && prdata_out[31:16] == 16'h0000) else $error("unimplemented bits set");
endmodule

// file: verification/rcc_reset_cause_tb_top.sv
`timescale 1ns/1ps
module rcc_reset_cause_tb_top;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, er;
  logic        master_clear_pin_in = 1'b0, regulator_standby_in = 1'b0, watchdog_config_fuse_in = 1'b0;
  logic        pready_out, pslverr_out, brownout_detect_en_out, watchdog_en_out, memory_bias_en_out;
  logic        retention_sleep_control_out, core_reset_req_out, irq_out;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [3:0]  pstrb_in = 4'hF;
  logic [10:0] ev_v = 11'h000;
  wire         reset_instr_in, illegal_opcode_in, illegal_addr_mode_in, uninit_pointer_in, trap_conflict_in;
  wire         config_mismatch_in, watchdog_timeout_in, brownout_in, deep_sleep_in, sleep_entry_in, idle_entry_in;
  int          n_fail = 0, n_tests = 0;
  // flag bit set by each event input, in ev_v order
  localparam int EB[11] = '{6, 14, 14, 14, 15, 9, 4, 1, 10, 3, 2};
  assign {idle_entry_in, sleep_entry_in, deep_sleep_in, brownout_in, watchdog_timeout_in, config_mismatch_in,
          trap_conflict_in, uninit_pointer_in, illegal_addr_mode_in, illegal_opcode_in, reset_instr_in} = ev_v;
  always #10 clk_in = ~clk_in;
  rcc_reset_cause dut_u (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel_in <= 1'b1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    i = 0;
    do begin @(posedge clk_in); i++; end while (pready_out !== 1'b1 && i < 50);
    if (pready_out !== 1'b1) begin n_fail++; end_of_test(); end
    rd = prdata_out; er = pslverr_out;
    psel_in <= 1'b0; penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_sw;
    apb(0, 12'h000, 0); chk(rd, 32'h3);
    apb(1, 12'h000, 32'hFFFFFFFF); chk(core_reset_req_out, 0);
    apb(0, 12'h000, 0); chk(rd, 32'hF7FF);
    chk(brownout_detect_en_out, 1);
    apb(1, 12'h000, 0); apb(0, 12'h000, 0); chk(rd, 0);
    chk(brownout_detect_en_out, 0);
    apb(0, 12'h00C, 0); chk(er, 1);
    chk(rd, 0);
  endtask
  task automatic t_events;
    apb(1, 12'h000, 32'h2000);
    for (int k = 0; k < 11; k++) begin
      ev_v <= 11'h001 << k; @(posedge clk_in); ev_v <= 11'h000; repeat (2) @(posedge clk_in);
      apb(0, 12'h000, 0); chk(rd, 32'h2000 | (32'h1 << EB[k]));
      apb(1, 12'h000, 32'h2000);
    end
    master_clear_pin_in <= 1'b1; repeat (6) @(posedge clk_in); master_clear_pin_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    apb(0, 12'h000, 0); chk(rd, 32'h2080);
  endtask
  task automatic t_ctl;
    watchdog_config_fuse_in <= 1'b1; repeat (5) @(posedge clk_in); chk(watchdog_en_out, 1);
    watchdog_config_fuse_in <= 1'b0; repeat (5) @(posedge clk_in); chk(watchdog_en_out, 0);
    apb(1, 12'h000, 0); regulator_standby_in <= 1'b1;
    repeat (3) @(posedge clk_in); chk(memory_bias_en_out, 0);
    apb(1, 12'h000, 32'h100); repeat (2) @(posedge clk_in); chk(memory_bias_en_out, 1);
    regulator_standby_in <= 1'b0; apb(1, 12'h000, 32'h1000); chk(retention_sleep_control_out, 1);
    apb(1, 12'h000, 0); chk(retention_sleep_control_out, 0);
  endtask
  task automatic t_irq;
    apb(0, 12'h004, 0); apb(1, 12'h008, 32'h40); chk(irq_out, 0);
    ev_v <= 11'h001; @(posedge clk_in); ev_v <= 11'h000;
    repeat (2) @(posedge clk_in); chk(irq_out, 1);
    apb(0, 12'h004, 0); chk(rd[6], 1); chk(irq_out, 0);
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    t_sw(); t_events(); t_ctl(); t_irq();
    end_of_test();
  end
endmodule
bind rcc_reset_cause rcc_reset_cause_chk chk_u (.*);
